// [hdl/sssc_top.sv]
`timescale 1ns/100ps
`include "sssc_regs.svh"
//
// Contract
// - Six-bit read-only counter of current synchronous REQ/ACK offset.
// - Offset reads zero when asynchronous, zero to thirty-two when synchronous.
// - Byte-length bit set means count in bytes, else logical blocks.
// - DMA requests on port B or A answered only while enabled.
// - Striping bit turns striping on in the data path.
// - Processor route sends data via data register, else via DMA.
// - LRC bit enables LRC generation on send and strip on receive.
// - Attention halt with instruction enable stops transfer on ATN in target mode.
// - Mirror restore: port A request mirrors B, B ack mirrors A.
// - Interrupt asserted while any enabled status bit set, until cleared.
// - Status bits set regardless of mask; pin-state bit reflects pin.
// - Write one clears status bit, except the two summary bits.
// - Sequence reject set when processor start refused.
// - Flag pipeline move from very-busy to busy.
// - Flag pipeline move from busy to idle.
// - Summary bits follow any unmasked bit of their source register.
// - Sequencer interrupt and sequencer stop flags set on their events.
// - Halt bits set only after sequencer halted; write one clears.
// - Offset error set on abnormal REQ/ACK behaviour.
// - Count underrun set in target mode on empty pipeline transfer.
// - LRC error and parity error halt bits set on their faults.
// - Selection timeout set when target fails before timeout expires.
// - Abort-done bit set when processor abort or kill completes.
// - Each status bit has a mask gating it onto the pin.
module sssc_top
    import sssc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire sssc_addr_t ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire sssc_byte_t WDATA,
    output sssc_byte_t RDATA,
    input wire logic SYNC_MODE,
    input wire logic OFS_INC,
    input wire logic OFS_DEC,
    input wire sssc_pipe_e PIPE_STATE,
    input wire logic SEQ_RUNNING,
    input wire logic SEQ_HALTED,
    input wire logic SEQ_START_REQ,
    input wire logic SEL_START,
    input wire logic SEQ_INT_EXEC,
    input wire logic SEQ_STOP_OK,
    input wire logic INSTR_ATTENTION_ENABLE,
    input wire logic ATN_IN,
    input wire logic XFER_ACTIVE,
    input wire logic TARGET_MODE,
    input wire logic XFER_BEGIN,
    input wire logic CHECK_WORD_BAD,
    input wire logic PARITY_BAD,
    input wire logic SEL_TIMEOUT,
    input wire logic ABORT_COMPLETE,
    input wire logic UNEXPECTED_EVENT_ANY,
    input wire logic DMA_REQ_PORT_A,
    input wire logic DMA_REQ_PORT_B,
    input wire logic DMA_ACK_PORT_A_IN,
    input wire logic FIFO_BUFFER_READY,
    output logic INT_OUT,
    output logic SEQ_START,
    output logic COUNT_IN_BYTES,
    output logic STRIPING_ON,
    output logic PROCESSOR_XFER,
    output logic DMA_XFER,
    output logic LRC_GEN_STRIP,
    output logic ATTENTION_HALT_NOW,
    output logic PORT_A_SERVICE,
    output logic PORT_B_SERVICE,
    output logic DMA_REQ_PORT_A_OUT,
    output logic DMA_ACK_PORT_B,
    output logic DMA_OTHER_OE_N
);
    import sssc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    sssc_byte_t aux_q, aux_d;
    logic [6:0] exc_q, exc_d;
    logic [5:0] halt_q, halt_d;
    logic [6:0] excm_q, excm_d;
    logic [5:0] haltm_q, haltm_d;
    logic [5:0] ofs_q, ofs_d;
    sssc_pipe_e pipe_q;
    logic [3:0] sync1_q, sync2_q;
    sssc_byte_t rdata_d;
    logic int_d;

    ////////////////////////////////////////////////////////////////////
    // Address decode
    wire logic wr_aux = WR && (ADDR == `SSSC_OFF_AUX);
    wire logic wr_exc = WR && (ADDR == `SSSC_OFF_EXC);
    wire logic wr_halt = WR && (ADDR == `SSSC_OFF_HALT);
    wire logic wr_excm = WR && (ADDR == `SSSC_OFF_EXCM);
    wire logic wr_haltm = WR && (ADDR == `SSSC_OFF_HALTM);

    // Pin inputs as seen after the second synchroniser stage
    wire logic atn_s = sync2_q[3];
    wire logic dreq_a_s = sync2_q[2];
    wire logic dreq_b_s = sync2_q[1];
    wire logic dack_a_s = sync2_q[0];

    // Event detection from the pipeline and the sequencer
    wire logic ev_vb = (pipe_q == SSSC_PIPE_VBUSY) &&
                       (PIPE_STATE == SSSC_PIPE_BUSY);
    wire logic ev_bi = (pipe_q == SSSC_PIPE_BUSY) &&
                       (PIPE_STATE == SSSC_PIPE_IDLE);
    wire logic irq_pending = |(exc_q & excm_q);
    // A start loses to a running sequencer, a pending irq or a selection
    wire logic ev_rej = SEQ_START_REQ &&
                        (SEQ_RUNNING || irq_pending || SEL_START);
    wire logic start_ok = SEQ_START_REQ && !ev_rej;

    // Halt events; latched only once the sequencer has halted
    wire logic [5:0] halt_ev = {
        XFER_ACTIVE && OFS_INC && ofs_q == `SSSC_OFS_MAX,
        TARGET_MODE && XFER_BEGIN && pipe_q == SSSC_PIPE_IDLE,
        CHECK_WORD_BAD,
        PARITY_BAD,
        SEL_TIMEOUT,
        ABORT_COMPLETE
    };
    wire logic [5:0] halt_set = SEQ_HALTED ? halt_ev : `SSSC_HALT_ZERO;

    // Summary bits are live views, not sticky flags
    wire logic uhs_sum = |(halt_q & haltm_q);
    wire logic [6:0] exc_view = {exc_q[6:4], UNEXPECTED_EVENT_ANY,
                                 uhs_sum, exc_q[1:0]};
    wire logic [6:0] exc_set = {ev_rej, ev_vb, ev_bi, 1'b0, 1'b0,
                                SEQ_INT_EXEC, SEQ_STOP_OK};
    // Summary positions ignore write-one-to-clear
    wire logic [6:0] exc_clr_mask = 7'h73;

    ////////////////////////////////////////////////////////////////////
    // Sticky flags: a set in the same cycle as a clear wins
    always_comb begin
        aux_d = wr_aux ? WDATA : aux_q;
        excm_d = wr_excm ? WDATA[6:0] : excm_q;
        haltm_d = wr_haltm ? WDATA[5:0] : haltm_q;
        exc_d = exc_q;
        if (wr_exc) begin
            exc_d = exc_q & ~(WDATA[6:0] & exc_clr_mask);
        end
        exc_d = (exc_d | exc_set) & exc_clr_mask;
        halt_d = halt_q;
        if (wr_halt) begin
            halt_d = halt_q & ~WDATA[5:0];
        end
        halt_d = halt_d | halt_set;
    end

    // Offset counter: clear when asynchronous, saturate at the top
    always_comb begin
        ofs_d = ofs_q;
        if (!SYNC_MODE || !XFER_ACTIVE) begin
            ofs_d = `SSSC_OFS_ZERO;
        end else if (OFS_INC && !OFS_DEC && ofs_q != `SSSC_OFS_MAX) begin
            ofs_d = ofs_q + 6'h01;
        end else if (OFS_DEC && !OFS_INC && ofs_q != `SSSC_OFS_ZERO) begin
            ofs_d = ofs_q - 6'h01;
        end
    end

    // Pin follows enabled status; pin state bit reads it back
    always_comb begin
        int_d = |({exc_d[6:4], UNEXPECTED_EVENT_ANY, |(halt_d & haltm_d),
                  exc_d[1:0]} & excm_d);
        case (ADDR)
            `SSSC_OFF_AUX: rdata_d = aux_q;
            `SSSC_OFF_EXC: rdata_d = {INT_OUT, exc_view};
            `SSSC_OFF_HALT: rdata_d = {2'b00, halt_q};
            `SSSC_OFF_EXCM: rdata_d = {1'b0, excm_q};
            `SSSC_OFF_HALTM: rdata_d = {2'b00, haltm_q};
            `SSSC_OFF_OFS: rdata_d = {2'b00, ofs_q};
            default: rdata_d = `SSSC_BYTE_ZERO;
        endcase
        if (!RD) begin
            rdata_d = `SSSC_BYTE_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers; reset clears all control and status
    always_ff @(posedge CLK) begin
        if (RST) begin
            aux_q <= `SSSC_BYTE_ZERO;
            exc_q <= 7'h00;
            halt_q <= `SSSC_HALT_ZERO;
            excm_q <= 7'h00;
            haltm_q <= `SSSC_HALT_ZERO;
            ofs_q <= `SSSC_OFS_ZERO;
            pipe_q <= SSSC_PIPE_IDLE;
        end else begin
            aux_q <= aux_d;
            exc_q <= exc_d;
            halt_q <= halt_d;
            excm_q <= excm_d;
            haltm_q <= haltm_d;
            ofs_q <= ofs_d;
            pipe_q <= PIPE_STATE;
        end
    end

    // ATN and DMA pins are asynchronous: two flops, only stage two is read
    // Costs two cycles of mirror latency, bought against metastability
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {ATN_IN, DMA_REQ_PORT_A, DMA_REQ_PORT_B,
                        DMA_ACK_PORT_A_IN};
            sync2_q <= sync1_q;
        end
    end

    // Registered outputs: interrupt pin, read data, start, then those driven by the control bits
    always_ff @(posedge CLK) begin
        if (RST) begin
            INT_OUT <= 1'b0;
            RDATA <= `SSSC_BYTE_ZERO;
            SEQ_START <= 1'b0;
            COUNT_IN_BYTES <= 1'b0;
            STRIPING_ON <= 1'b0;
            PROCESSOR_XFER <= 1'b0;
            DMA_XFER <= 1'b0;
            LRC_GEN_STRIP <= 1'b0;
            ATTENTION_HALT_NOW <= 1'b0;
            PORT_A_SERVICE <= 1'b0;
            PORT_B_SERVICE <= 1'b0;
            DMA_REQ_PORT_A_OUT <= 1'b0;
            DMA_ACK_PORT_B <= 1'b0;
            DMA_OTHER_OE_N <= 1'b1;
        end else begin
            INT_OUT <= int_d;
            RDATA <= rdata_d;
            SEQ_START <= start_ok;
            COUNT_IN_BYTES <= aux_q[`SSSC_AUX_BYTES];
            STRIPING_ON <= aux_q[`SSSC_AUX_STRIPE];
            PROCESSOR_XFER <= aux_q[`SSSC_AUX_PROC] &&
                              FIFO_BUFFER_READY;
            DMA_XFER <= !aux_q[`SSSC_AUX_PROC];
            LRC_GEN_STRIP <= aux_q[`SSSC_AUX_LRC];
            ATTENTION_HALT_NOW <= aux_q[`SSSC_AUX_ATNH] &&
                INSTR_ATTENTION_ENABLE && atn_s && XFER_ACTIVE &&
                TARGET_MODE;
            if (aux_q[`SSSC_AUX_MIRROR]) begin
                PORT_A_SERVICE <= 1'b0;
                PORT_B_SERVICE <= 1'b0;
                DMA_REQ_PORT_A_OUT <= dreq_b_s;
                DMA_ACK_PORT_B <= dack_a_s;
                DMA_OTHER_OE_N <= 1'b1;
            end else begin
                PORT_A_SERVICE <= aux_q[`SSSC_AUX_PA] &&
                                  dreq_a_s;
                PORT_B_SERVICE <= aux_q[`SSSC_AUX_PB] &&
                                  dreq_b_s;
                DMA_REQ_PORT_A_OUT <= 1'b0;
                DMA_ACK_PORT_B <= 1'b0;
                DMA_OTHER_OE_N <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_OFS_RANGE: assert property (@(posedge CLK) disable iff (RST)
        ofs_q <= `SSSC_OFS_MAX) else $error("offset above limit");
    AST_OFS_ASYNC: assert property (@(posedge CLK) disable iff (RST)
        !SYNC_MODE |=> ofs_q == `SSSC_OFS_ZERO)
        else $error("offset not zero when async");
    AST_VB_FLAG: assert property (@(posedge CLK) disable iff (RST)
        ev_vb |=> exc_q[5]) else $error("very busy flag missed");
    AST_BI_FLAG: assert property (@(posedge CLK) disable iff (RST)
        ev_bi |=> exc_q[4]) else $error("busy idle flag missed");
    AST_REJECT: assert property (@(posedge CLK) disable iff (RST)
        SEQ_START_REQ && SEQ_RUNNING |=> exc_q[6] && !SEQ_START)
        else $error("running start not rejected");
    AST_INT_PIN: assert property (@(posedge CLK) disable iff (RST)
        |(exc_view & excm_q) |-> ##[0:1] INT_OUT)
        else $error("interrupt pin not raised");
    AST_HALT_GATE: assert property (@(posedge CLK) disable iff (RST)
        !SEQ_HALTED && !wr_halt |=> halt_q == $past(halt_q))
        else $error("halt bit set while running");
    AST_PORT_A: assert property (@(posedge CLK) disable iff (RST)
        !aux_q[`SSSC_AUX_PA] |=> !PORT_A_SERVICE)
        else $error("port A served while disabled");
    AST_MIRROR: assert property (@(posedge CLK) disable iff (RST)
        aux_q[`SSSC_AUX_MIRROR] |=>
        DMA_REQ_PORT_A_OUT == $past(dreq_b_s))
        else $error("port A request not mirrored");
    AST_MIRROR_ACK: assert property (@(posedge CLK) disable iff (RST)
        aux_q[`SSSC_AUX_MIRROR] |=>
        DMA_ACK_PORT_B == $past(dack_a_s) && DMA_OTHER_OE_N)
        else $error("port B ack not mirrored");
    // Halt and mask writes go elsewhere, so the summary must survive
    AST_SUMMARY: assert property (@(posedge CLK) disable iff (RST)
        wr_exc && WDATA[`SSSC_EXC_UHS] && uhs_sum |=> exc_view[2])
        else $error("summary bit cleared by write");
    AST_EXC_CLEAR: assert property (@(posedge CLK) disable iff (RST)
        wr_exc && WDATA[`SSSC_EXC_SHLT] && !SEQ_STOP_OK |=> !exc_q[0])
        else $error("stop flag not cleared");
    AST_SEL_REJECT: assert property (@(posedge CLK) disable iff (RST)
        SEQ_START_REQ && SEL_START |=> exc_q[6] && !SEQ_START)
        else $error("selection start not preferred");
    AST_SIRQ_SET: assert property (@(posedge CLK) disable iff (RST)
        SEQ_INT_EXEC |=> exc_q[1])
        else $error("sequencer irq flag missed");
    AST_SHLT_SET: assert property (@(posedge CLK) disable iff (RST)
        SEQ_STOP_OK |=> exc_q[0])
        else $error("sequencer stop flag missed");
    AST_OFS_ERR: assert property (@(posedge CLK) disable iff (RST)
        SEQ_HALTED && XFER_ACTIVE && OFS_INC && ofs_q == `SSSC_OFS_MAX
        |=> halt_q[5]) else $error("offset error missed");
    AST_UNDERRUN: assert property (@(posedge CLK) disable iff (RST)
        SEQ_HALTED && TARGET_MODE && XFER_BEGIN &&
        pipe_q == SSSC_PIPE_IDLE |=> halt_q[4])
        else $error("count underrun missed");
    AST_LRC_ERR: assert property (@(posedge CLK) disable iff (RST)
        SEQ_HALTED && CHECK_WORD_BAD |=> halt_q[3])
        else $error("check word error missed");
    AST_SEL_TMO: assert property (@(posedge CLK) disable iff (RST)
        SEQ_HALTED && SEL_TIMEOUT |=> halt_q[1])
        else $error("selection timeout missed");
    AST_ABORT: assert property (@(posedge CLK) disable iff (RST)
        SEQ_HALTED && ABORT_COMPLETE |=> halt_q[0])
        else $error("abort done missed");
    AST_HALT_CLEAR: assert property (@(posedge CLK) disable iff (RST)
        wr_halt && WDATA[2] && !(SEQ_HALTED && PARITY_BAD)
        |=> !halt_q[2]) else $error("halt bit not cleared");
    AST_PORT_B: assert property (@(posedge CLK) disable iff (RST)
        !aux_q[`SSSC_AUX_PB] |=> !PORT_B_SERVICE)
        else $error("port B served while disabled");
    AST_BYTES: assert property (@(posedge CLK) disable iff (RST)
        aux_q[`SSSC_AUX_BYTES] |=> COUNT_IN_BYTES)
        else $error("byte count mode not shown");
    AST_STRIPE: assert property (@(posedge CLK) disable iff (RST)
        aux_q[`SSSC_AUX_STRIPE] |=> STRIPING_ON)
        else $error("striping not on");
    AST_LRC_ON: assert property (@(posedge CLK) disable iff (RST)
        aux_q[`SSSC_AUX_LRC] |=> LRC_GEN_STRIP)
        else $error("check word handling not on");
    // Processor route must wait for the buffer-ready flag
    AST_PROC_GATE: assert property (@(posedge CLK) disable iff (RST)
        !FIFO_BUFFER_READY |=> !PROCESSOR_XFER)
        else $error("processor route without ready");
    AST_DMA_ROUTE: assert property (@(posedge CLK) disable iff (RST)
        aux_q[`SSSC_AUX_PROC] |=> !DMA_XFER)
        else $error("dma route while processor routed");
    AST_ATN_GATE: assert property (@(posedge CLK) disable iff (RST)
        !aux_q[`SSSC_AUX_ATNH] |=> !ATTENTION_HALT_NOW)
        else $error("attention halt while disabled");
    // Checked across the reset edge itself, so no disable here
    AST_RESET_PINS: assert property (@(posedge CLK)
        RST |=> DMA_OTHER_OE_N && !INT_OUT && !PORT_A_SERVICE)
        else $error("outputs not idle after reset");
endmodule

// [inc/sssc_pkg.sv]
package sssc_pkg;
    typedef logic [7:0] sssc_byte_t;
    typedef logic [6:0] sssc_addr_t;
    typedef enum logic [1:0] {
        SSSC_PIPE_IDLE,
        SSSC_PIPE_BUSY,
        SSSC_PIPE_VBUSY
    } sssc_pipe_e;
endpackage

// [inc/sssc_regs.svh]
`ifndef SSSC_REGS_SVH
`define SSSC_REGS_SVH
// Register offsets on the processor port
`define SSSC_OFF_AUX 7'h02
`define SSSC_OFF_EXC 7'h04
`define SSSC_OFF_HALT 7'h06
`define SSSC_OFF_EXCM 7'h0a
`define SSSC_OFF_HALTM 7'h0c
`define SSSC_OFF_UEVM 7'h0e
`define SSSC_OFF_OFS 7'h4c
// Auxiliary control field positions
`define SSSC_AUX_BYTES 7
`define SSSC_AUX_PB 6
`define SSSC_AUX_PA 5
`define SSSC_AUX_STRIPE 4
`define SSSC_AUX_PROC 3
`define SSSC_AUX_LRC 2
`define SSSC_AUX_ATNH 1
`define SSSC_AUX_MIRROR 0
// Exception status field positions
`define SSSC_EXC_PIN 7
`define SSSC_EXC_REJ 6
`define SSSC_EXC_VB 5
`define SSSC_EXC_BI 4
`define SSSC_EXC_UEV 3
`define SSSC_EXC_UHS 2
`define SSSC_EXC_SIRQ 1
`define SSSC_EXC_SHLT 0
// Offset counter limits and reset values
`define SSSC_OFS_MAX 6'h20
`define SSSC_OFS_ZERO 6'h00
`define SSSC_BYTE_ZERO 8'h00
`define SSSC_HALT_ZERO 6'h00
`endif

// [test/sssc_dma_peer.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Far-side DMA peers: slave on port B, master on port A
module sssc_dma_peer (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic slow,
    input wire logic req_a_mir,
    output logic req_a,
    output logic req_b,
    output logic ack_a
);
    logic [2:0] wait_q;
    // Both peers request while traffic is wanted; master answers late if slow
    always_ff @(posedge clk) begin
        if (rst || !go) begin
            req_a <= 1'b0;
            req_b <= 1'b0;
            ack_a <= 1'b0;
            wait_q <= 3'h0;
        end else begin
            req_a <= 1'b1;
            req_b <= 1'b1;
            if (!req_a_mir) begin
                ack_a <= 1'b0;
                wait_q <= 3'h0;
            end else if (wait_q >= (slow ? 3'h4 : 3'h0)) begin
                ack_a <= 1'b1;
            end else begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule

// [test/testbench.sv]
`timescale 1ns/100ps
`include "sssc_regs.svh"
module testbench;
    import sssc_pkg::*;
    typedef struct packed {
        logic [7:0] aux;
        logic [7:0] exp;
    } sssc_row_s;
    logic CLK = 0, RST = 1, WR = 0, RD = 0, go = 0, slow = 0;
    sssc_addr_t ADDR = '0;
    sssc_byte_t WDATA = '0, RDATA;
    sssc_pipe_e PIPE_STATE = SSSC_PIPE_IDLE;
    logic SYNC_MODE = 0, OFS_INC = 0, OFS_DEC = 0, SEQ_RUNNING = 0;
    logic SEQ_HALTED = 0, SEQ_START_REQ = 0, INSTR_ATTENTION_ENABLE = 0;
    logic ATN_IN = 0, XFER_ACTIVE = 0, TARGET_MODE = 0;
    logic UNEXPECTED_EVENT_ANY = 0, sel = 0, fbr = 1;
    logic [4:0] ev = '0;
    logic [1:0] sq = '0;
    logic req_a, req_b, ack_a, INT_OUT, SEQ_START, COUNT_IN_BYTES;
    logic STRIPING_ON, PROCESSOR_XFER, DMA_XFER, LRC_GEN_STRIP;
    logic ATTENTION_HALT_NOW, PORT_A_SERVICE, PORT_B_SERVICE;
    logic DMA_REQ_PORT_A_OUT, DMA_ACK_PORT_B, DMA_OTHER_OE_N;
    logic [7:0] ov;
    int checked = 0, miscompares = 0, cycles = 0;
    // Aux value, then expected {bytes,stripe,lrc,dma,proc,svcA,svcB,oe_n}
    sssc_row_s rows [8] = '{'{8'h80, 8'h90}, '{8'h40, 8'h12},
        '{8'h20, 8'h14}, '{8'h60, 8'h16}, '{8'h10, 8'h50},
        '{8'h04, 8'h30}, '{8'h08, 8'h08}, '{8'h61, 8'h11}};
    assign ov = {COUNT_IN_BYTES, STRIPING_ON, LRC_GEN_STRIP, DMA_XFER,
        PROCESSOR_XFER, PORT_A_SERVICE, PORT_B_SERVICE, DMA_OTHER_OE_N};
    always #20 CLK = ~CLK;
    sssc_top dut (
        .CLK, .RST, .ADDR, .WR, .RD, .WDATA, .RDATA, .SYNC_MODE,
        .OFS_INC, .OFS_DEC, .PIPE_STATE, .SEQ_RUNNING, .SEQ_HALTED,
        .SEQ_START_REQ, .SEL_START(sel), .SEQ_INT_EXEC(sq[1]),
        .SEQ_STOP_OK(sq[0]), .INSTR_ATTENTION_ENABLE, .ATN_IN,
        .XFER_ACTIVE, .TARGET_MODE, .XFER_BEGIN(ev[4]),
        .CHECK_WORD_BAD(ev[3]), .PARITY_BAD(ev[2]),
        .SEL_TIMEOUT(ev[1]), .ABORT_COMPLETE(ev[0]),
        .UNEXPECTED_EVENT_ANY, .DMA_REQ_PORT_A(req_a),
        .DMA_REQ_PORT_B(req_b), .DMA_ACK_PORT_A_IN(ack_a),
        .FIFO_BUFFER_READY(fbr), .INT_OUT, .SEQ_START, .COUNT_IN_BYTES,
        .STRIPING_ON, .PROCESSOR_XFER, .DMA_XFER, .LRC_GEN_STRIP,
        .ATTENTION_HALT_NOW, .PORT_A_SERVICE, .PORT_B_SERVICE,
        .DMA_REQ_PORT_A_OUT, .DMA_ACK_PORT_B, .DMA_OTHER_OE_N
    );
    sssc_dma_peer peer (.clk(CLK), .rst(RST), .go(go), .slow(slow),
        .req_a_mir(DMA_REQ_PORT_A_OUT), .req_a(req_a), .req_b(req_b),
        .ack_a(ack_a));
    ////////////////////////////////////////////////////////////////////////////
    // Compare, bus cycles and small helpers
    task automatic chk(input logic [7:0] s, input logic [7:0] e,
                       input string n);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Strobe dropped for a full cycle so back-to-back calls never clash
    task automatic wr(input sssc_addr_t a, input sssc_byte_t d);
        ADDR = a;
        WDATA = d;
        WR = 1'b1;
        @(negedge CLK);
        WR = 1'b0;
        @(negedge CLK);
    endtask
    task automatic rd(input sssc_addr_t a, input sssc_byte_t e);
        ADDR = a;
        RD = 1'b1;
        @(negedge CLK);
        RD = 1'b0;
        chk(RDATA, e, $sformatf("reg %h", a));
        @(negedge CLK);
    endtask
    task automatic pl(ref logic s);
        s = 1'b1;
        @(negedge CLK);
        s = 1'b0;
        @(negedge CLK);
    endtask
    // Bounded wait; a miss shows up in the compare that follows
    task automatic wt(ref logic s, input logic v);
        for (int i = 0; i < 20 && s !== v; i++) @(negedge CLK);
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Cut a hang short well beyond the expected run of about 400 cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(negedge CLK);
        RST = 1'b0;
        chk(8'({INT_OUT, DMA_OTHER_OE_N}), 8'h01, "reset pins");
        rd(`SSSC_OFF_AUX, 8'h00);
        rd(`SSSC_OFF_EXC, 8'h00);
        rd(`SSSC_OFF_HALT, 8'h00);
        rd(`SSSC_OFF_OFS, 8'h00);
        go = 1'b1;
        foreach (rows[i]) begin
            wr(`SSSC_OFF_AUX, rows[i].aux);
            chk(ov, rows[i].exp, "aux outputs");
            rd(`SSSC_OFF_AUX, rows[i].aux);
        end
        fbr = 1'b0;
        wr(`SSSC_OFF_AUX, 8'h08);
        chk(ov, 8'h00, "proc not ready");
        fbr = 1'b1;
        // Mirror handshake with a prompt and then a slow port A master
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            wr(`SSSC_OFF_AUX, 8'h00);
            wr(`SSSC_OFF_AUX, 8'h01);
            wt(DMA_ACK_PORT_B, 1'b1);
            chk(8'({DMA_REQ_PORT_A_OUT, DMA_ACK_PORT_B, DMA_OTHER_OE_N,
                PORT_A_SERVICE}), 8'h0e, "mirror");
        end
        wr(`SSSC_OFF_AUX, 8'h00);
        chk(8'({DMA_REQ_PORT_A_OUT, DMA_OTHER_OE_N}), 8'h00, "unmirror");
        wr(`SSSC_OFF_AUX, 8'h02);
        {ATN_IN, XFER_ACTIVE, TARGET_MODE} = 3'b111;
        repeat (6) @(negedge CLK);
        chk(8'(ATTENTION_HALT_NOW), 8'h00, "atn no enable");
        INSTR_ATTENTION_ENABLE = 1'b1;
        wt(ATTENTION_HALT_NOW, 1'b1);
        chk(8'(ATTENTION_HALT_NOW), 8'h01, "atn halt");
        ATN_IN = 1'b0;
        wr(`SSSC_OFF_AUX, 8'h00);
        // Offset counter up to its ceiling of 32 and back
        SYNC_MODE = 1'b1;
        repeat (3) pl(OFS_INC);
        rd(`SSSC_OFF_OFS, 8'h03);
        pl(OFS_DEC);
        rd(`SSSC_OFF_OFS, 8'h02);
        repeat (31) pl(OFS_INC);
        rd(`SSSC_OFF_OFS, 8'h20);
        repeat (32) pl(OFS_DEC);
        SYNC_MODE = 1'b0;
        rd(`SSSC_OFF_OFS, 8'h00);
        wr(`SSSC_OFF_HALT, 8'h3f);
        for (int j = 0; j < 2; j++) begin
            sq = 2'h1 << j;
            @(negedge CLK);
            sq = 2'h0;
            rd(`SSSC_OFF_EXC, 8'h01 << j);
            chk(8'(INT_OUT), 8'h00, "masked int");
            wr(`SSSC_OFF_EXC, 8'h01 << j);
            rd(`SSSC_OFF_EXC, 8'h00);
        end
        wr(`SSSC_OFF_EXCM, 8'h01);
        sq = 2'h1;
        @(negedge CLK);
        sq = 2'h0;
        @(negedge CLK);
        chk(8'(INT_OUT), 8'h01, "int on");
        rd(`SSSC_OFF_EXC, 8'h81);
        wr(`SSSC_OFF_EXC, 8'h01);
        chk(8'(INT_OUT), 8'h00, "int off");
        wr(`SSSC_OFF_EXCM, 8'h00);
        PIPE_STATE = SSSC_PIPE_VBUSY;
        @(negedge CLK);
        PIPE_STATE = SSSC_PIPE_BUSY;
        @(negedge CLK);
        PIPE_STATE = SSSC_PIPE_IDLE;
        @(negedge CLK);
        rd(`SSSC_OFF_EXC, 8'h30);
        wr(`SSSC_OFF_EXC, 8'h30);
        SEQ_RUNNING = 1'b1;
        pl(SEQ_START_REQ);
        rd(`SSSC_OFF_EXC, 8'h40);
        wr(`SSSC_OFF_EXC, 8'h40);
        SEQ_RUNNING = 1'b0;
        sel = 1'b1;
        pl(SEQ_START_REQ);
        rd(`SSSC_OFF_EXC, 8'h40);
        wr(`SSSC_OFF_EXC, 8'h40);
        sel = 1'b0;
        SEQ_START_REQ = 1'b1;
        @(negedge CLK);
        SEQ_START_REQ = 1'b0;
        chk(8'(SEQ_START), 8'h01, "start accepted");
        rd(`SSSC_OFF_EXC, 8'h00);
        // Halt faults only land once the sequencer has halted
        ev = 5'h04;
        @(negedge CLK);
        ev = 5'h00;
        rd(`SSSC_OFF_HALT, 8'h00);
        SEQ_HALTED = 1'b1;
        for (int i = 0; i < 5; i++) begin
            ev = 5'h01 << i;
            @(negedge CLK);
            ev = 5'h00;
            rd(`SSSC_OFF_HALT, 8'h01 << i);
            wr(`SSSC_OFF_HALT, 8'h01 << i);
            rd(`SSSC_OFF_HALT, 8'h00);
        end
        SYNC_MODE = 1'b1;
        repeat (33) pl(OFS_INC);
        SYNC_MODE = 1'b0;
        rd(`SSSC_OFF_HALT, 8'h20);
        wr(`SSSC_OFF_HALT, 8'h20);
        ev = 5'h04;
        @(negedge CLK);
        ev = 5'h00;
        wr(`SSSC_OFF_HALTM, 8'h04);
        wr(`SSSC_OFF_EXC, 8'h0c);
        rd(`SSSC_OFF_EXC, 8'h04);
        UNEXPECTED_EVENT_ANY = 1'b1;
        wr(`SSSC_OFF_EXCM, 8'h0c);
        rd(`SSSC_OFF_EXC, 8'h8c);
        wr(`SSSC_OFF_HALT, 8'h04);
        UNEXPECTED_EVENT_ANY = 1'b0;
        repeat (2) @(negedge CLK);
        chk(8'(INT_OUT), 8'h00, "int after clear");
        finish_test;
    end
endmodule
